// ---- verilog/uart_rx_pkg.sv ----
package uart_rx_pkg;

    // Register addresses
    localparam logic [15:0] ADDR_BAUD = 16'hff71;
    localparam logic [15:0] ADDR_RXBUF = 16'hff72;
    localparam logic [15:0] ADDR_STATUS = 16'hff73;
    localparam logic [15:0] ADDR_PORT1_DIR = 16'hff21;

    // Reset values
    localparam logic [7:0] BAUD_RESET = 8'h1f;
    localparam logic [7:0] STATUS_RESET = 8'h00;
    localparam logic [7:0] RXBUF_RESET = 8'hff;
    localparam logic [7:0] PORT1_DIR_RESET = 8'hff;
    localparam logic [7:0] READ_UNMAPPED = 8'h00;

    // Field positions
    localparam int PE_BIT = 2;
    localparam int FE_BIT = 1;
    localparam int OVE_BIT = 0;
    localparam int SEL_HI_BIT = 7;
    localparam int SEL_LO_BIT = 6;
    localparam int DIV_MSB = 4;
    localparam int TX_PIN = 4;
    localparam int RX_PIN = 3;
    localparam logic [7:0] BAUD_WRITE_MASK = 8'hdf;

    // Base clock prescaler: fx/4, fx/16, fx/64
    localparam int PRE_W = 6;
    localparam logic [5:0] PRE_MASK_4 = 6'h03;
    localparam logic [5:0] PRE_MASK_16 = 6'h0f;
    localparam logic [5:0] PRE_MASK_64 = 6'h3f;

    typedef enum logic [1:0] {
        BASE_TIMER = 2'b00,
        BASE_DIV4 = 2'b01,
        BASE_DIV16 = 2'b10,
        BASE_DIV64 = 2'b11
    } base_sel_t;

    typedef enum logic [1:0] {
        PAR_NONE = 2'b00,
        PAR_ZERO = 2'b01,
        PAR_ODD = 2'b10,
        PAR_EVEN = 2'b11
    } parity_mode_t;

    typedef enum logic [2:0] {
        RX_IDLE = 3'b000,
        RX_START = 3'b001,
        RX_DATA = 3'b011,
        RX_PARITY = 3'b010,
        RX_STOP = 3'b110
    } rx_state_t;

    localparam logic [2:0] LAST_BIT_8 = 3'h7;
    localparam logic [2:0] LAST_BIT_7 = 3'h6;
    localparam logic [4:0] DIV_MIN = 5'h08;

endpackage

// ---- verilog/baud_divider.sv ----
`timescale 1ns/1ns
`default_nettype none
module baud_divider (
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire logic clk_en,
    input wire logic base_tick,
    input wire logic restart,
    input wire logic [4:0] divisor,
    output logic count_tick,
    output logic rate_tick
);

    logic [4:0] count_q;
    logic half_q;
    logic wrap;

    // Divide by k, then by two for the bit rate
    assign wrap = (count_q == divisor - 5'h01);
    assign count_tick = base_tick & wrap & ~restart;
    assign rate_tick = count_tick & half_q;

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            count_q <= 5'h00;
            half_q <= 1'b0;
        end else if (clk_en) begin
            if (restart) begin
                count_q <= 5'h00;
                half_q <= 1'b0;
            end else if (base_tick) begin
                count_q <= wrap ? 5'h00 : count_q + 5'h01;
                half_q <= wrap ? ~half_q : half_q;
            end
        end
    end

endmodule
`default_nettype wire

// ---- verilog/uart_rx_error_and_baud_gen.sv ----
`timescale 1ns/1ns
`default_nettype none
// Summary of operation
// - Reset, power off, receive off clear status
// - Status read returns flags then clears
// - Status is read-only, whole byte
// - Parity mismatch on completion sets parity flag
// - Missing high stop bit sets framing flag
// - Only first stop bit is checked
// - Unread buffer plus new frame sets overrun
// - Overrun discards new byte, keeps old
// - Status read inserts one wait cycle
// - Baud register resets to timer base clock, maximum divider
// - Base clock: timer, fx/4, fx/16, fx/64
// - Divider k from 8 to 31
// - Bit rate is divider output halved
// - Direction bit 0 drives, 1 inputs; reset ones
// - Zero parity mode never flags parity
module uart_rx_error_and_baud_gen (
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire logic clk_en,
    input wire logic [15:0] cpu_addr,
    input wire logic cpu_rd_en,
    input wire logic cpu_wr_en,
    input wire logic [7:0] cpu_wdata,
    output logic [7:0] cpu_rdata,
    output logic cpu_wait,
    input wire logic serial_power_enable,
    input wire logic receive_enable,
    input wire logic transmit_enable,
    input wire logic [1:0] parity_select,
    input wire logic char_len_8,
    input wire logic timer_fifty_output,
    input wire logic serial_rx_line,
    input wire logic tx_pin_latch,
    input wire logic tx_serial_data,
    output logic serial_tx_line,
    output logic serial_tx_oe_n,
    output logic [7:0] port1_direction,
    output logic bit_rate_tick,
    output logic rx_buffer_full
);

    ////////////////////////////////////////////////////////////////////////
    // Register decode
    logic [7:0] baud_q, status_q, rxbuf_q, port1_dir_q, rdata_q;
    logic wait_q, full_q;
    wire hit_baud = (cpu_addr == uart_rx_pkg::ADDR_BAUD);
    wire hit_status = (cpu_addr == uart_rx_pkg::ADDR_STATUS);
    wire hit_rxbuf = (cpu_addr == uart_rx_pkg::ADDR_RXBUF);
    wire hit_dir = (cpu_addr == uart_rx_pkg::ADDR_PORT1_DIR);
    assign cpu_wait = cpu_rd_en & hit_status & ~wait_q;
    wire rd_take = cpu_rd_en & ~cpu_wait;
    wire status_rd = rd_take & hit_status;
    wire rxbuf_rd = rd_take & hit_rxbuf;
    wire wr_baud = cpu_wr_en & hit_baud;
    wire wr_dir = cpu_wr_en & hit_dir;
    wire rx_on = serial_power_enable & receive_enable;
    wire [7:0] rdata_d = hit_baud ? baud_q :
                         hit_status ? status_q :
                         hit_rxbuf ? rxbuf_q :
                         hit_dir ? port1_dir_q : uart_rx_pkg::READ_UNMAPPED;

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            rdata_q <= uart_rx_pkg::READ_UNMAPPED;
            wait_q <= 1'b0;
        end else if (clk_en) begin
            wait_q <= cpu_wait;
            if (rd_take) begin
                rdata_q <= rdata_d;
            end
        end
    end
    assign cpu_rdata = rdata_q;

    // Divider rewrites are legal only while idle; not policed here
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            baud_q <= uart_rx_pkg::BAUD_RESET;
            port1_dir_q <= uart_rx_pkg::PORT1_DIR_RESET;
        end else if (clk_en) begin
            if (wr_baud) begin
                baud_q <= cpu_wdata & uart_rx_pkg::BAUD_WRITE_MASK;
            end
            if (wr_dir) begin
                port1_dir_q <= cpu_wdata;
            end
        end
    end
    assign port1_direction = port1_dir_q;

    ////////////////////////////////////////////////////////////////////////
    // Pins
    logic rx_m_q, rx_s_q, tm_m_q, tm_s_q, tm_d_q, tx_q;
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            rx_m_q <= 1'b1;
            rx_s_q <= 1'b1;
            tm_m_q <= 1'b0;
            tm_s_q <= 1'b0;
            tm_d_q <= 1'b0;
            tx_q <= 1'b1;
        end else if (clk_en) begin
            rx_m_q <= serial_rx_line;
            rx_s_q <= rx_m_q;
            tm_m_q <= timer_fifty_output;
            tm_s_q <= tm_m_q;
            tm_d_q <= tm_s_q;
            // Port latch drives the pin; with transmit on, serial data is ANDed with the latch
            tx_q <= (serial_power_enable & transmit_enable) ?
                    tx_serial_data & tx_pin_latch : tx_pin_latch;
        end
    end
    // Direction 0 turns the output buffer on
    assign serial_tx_oe_n = port1_dir_q[uart_rx_pkg::TX_PIN];
    assign serial_tx_line = tx_q;
    // Line reads high while powered down
    wire rx_bit = serial_power_enable ? rx_s_q : 1'b1;

    ////////////////////////////////////////////////////////////////////////
    // Baud generation
    logic [uart_rx_pkg::PRE_W-1:0] pre_q;
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            pre_q <= '0;
        end else if (clk_en) begin
            pre_q <= serial_power_enable ?
                     pre_q + 6'h01 : '0;
        end
    end
    wire [1:0] base_sel = {baud_q[uart_rx_pkg::SEL_HI_BIT],
                           baud_q[uart_rx_pkg::SEL_LO_BIT]};
    wire tm_rise = tm_s_q & ~tm_d_q;
    logic base_tick;
    always_comb begin
        case (base_sel)
            uart_rx_pkg::BASE_TIMER: base_tick = tm_rise;
            uart_rx_pkg::BASE_DIV4:
                base_tick = &(pre_q | ~uart_rx_pkg::PRE_MASK_4);
            uart_rx_pkg::BASE_DIV16:
                base_tick = &(pre_q | ~uart_rx_pkg::PRE_MASK_16);
            default: base_tick = &(pre_q | ~uart_rx_pkg::PRE_MASK_64);
        endcase
    end

    logic half_tick, rx_restart;
    wire [4:0] divisor = baud_q[uart_rx_pkg::DIV_MSB:0];
    baud_divider u_div (
        .sys_clk(sys_clk),
        .rst_n(rst_n),
        .clk_en(clk_en & serial_power_enable),
        // Gated so a frozen divider cannot pulse on timer edges
        .base_tick(base_tick & serial_power_enable),
        .restart(rx_restart),
        .divisor(divisor),
        .count_tick(half_tick),
        .rate_tick(bit_rate_tick)
    );

    ////////////////////////////////////////////////////////////////////////
    // Receiver: samples mid-bit on every second half tick
    uart_rx_pkg::rx_state_t st_q, st_d;
    logic phase_q, par_acc_q, pe_pend_q;
    logic [2:0] bit_cnt_q;
    logic [7:0] shift_q;
    wire sample = half_tick & ~phase_q;
    wire [2:0] last_bit = char_len_8 ? uart_rx_pkg::LAST_BIT_8 :
                                       uart_rx_pkg::LAST_BIT_7;
    wire par_check = parity_select[1];
    wire par_bad = (parity_select == uart_rx_pkg::PAR_ODD) ?
                   ~(par_acc_q ^ rx_bit) : (par_acc_q ^ rx_bit);
    assign rx_restart = (st_q == uart_rx_pkg::RX_IDLE) & rx_on & ~rx_bit;
    // Stop check looks at the first stop bit only
    wire frame_done = rx_on & sample & (st_q == uart_rx_pkg::RX_STOP);
    wire [7:0] rx_byte = char_len_8 ? shift_q : {1'b0, shift_q[7:1]};

    always_comb begin
        st_d = st_q;
        case (st_q)
            uart_rx_pkg::RX_IDLE:
                if (rx_restart) st_d = uart_rx_pkg::RX_START;
            uart_rx_pkg::RX_START:
                if (sample) st_d = rx_bit ? uart_rx_pkg::RX_IDLE :
                                            uart_rx_pkg::RX_DATA;
            uart_rx_pkg::RX_DATA:
                if (sample && bit_cnt_q == last_bit)
                    st_d = (parity_select == uart_rx_pkg::PAR_NONE) ?
                           uart_rx_pkg::RX_STOP : uart_rx_pkg::RX_PARITY;
            uart_rx_pkg::RX_PARITY:
                if (sample) st_d = uart_rx_pkg::RX_STOP;
            uart_rx_pkg::RX_STOP:
                if (sample) st_d = uart_rx_pkg::RX_IDLE;
            default: st_d = uart_rx_pkg::RX_IDLE;
        endcase
        if (!rx_on) st_d = uart_rx_pkg::RX_IDLE;
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            st_q <= uart_rx_pkg::RX_IDLE;
            phase_q <= 1'b0;
            bit_cnt_q <= 3'h0;
            shift_q <= 8'h00;
            par_acc_q <= 1'b0;
            pe_pend_q <= 1'b0;
        end else if (clk_en) begin
            st_q <= st_d;
            if (rx_restart) begin
                phase_q <= 1'b0;
                bit_cnt_q <= 3'h0;
                par_acc_q <= 1'b0;
                pe_pend_q <= 1'b0;
            end else if (half_tick) begin
                phase_q <= ~phase_q;
            end
            if (sample && st_q == uart_rx_pkg::RX_DATA) begin
                shift_q <= {rx_bit, shift_q[7:1]};
                par_acc_q <= par_acc_q ^ rx_bit;
                bit_cnt_q <= bit_cnt_q + 3'h1;
            end
            if (sample && st_q == uart_rx_pkg::RX_PARITY) begin
                pe_pend_q <= par_check & par_bad;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Receive buffer and error status
    wire overrun = full_q & ~rxbuf_rd;
    logic [7:0] new_flags;
    always_comb begin
        new_flags = uart_rx_pkg::STATUS_RESET;
        new_flags[uart_rx_pkg::PE_BIT] = pe_pend_q;
        new_flags[uart_rx_pkg::FE_BIT] = ~rx_bit;
        new_flags[uart_rx_pkg::OVE_BIT] = overrun;
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            status_q <= uart_rx_pkg::STATUS_RESET;
            rxbuf_q <= uart_rx_pkg::RXBUF_RESET;
            full_q <= 1'b0;
        end else if (clk_en) begin
            if (!rx_on) begin
                status_q <= uart_rx_pkg::STATUS_RESET;
            end else if (frame_done) begin
                // New frame beats a same-cycle read clear
                status_q <= new_flags;
            end else if (status_rd) begin
                status_q <= uart_rx_pkg::STATUS_RESET;
            end
            if (!serial_power_enable) begin
                rxbuf_q <= uart_rx_pkg::RXBUF_RESET;
                full_q <= 1'b0;
            end else if (frame_done && !overrun) begin
                rxbuf_q <= rx_byte;
                full_q <= 1'b1;
            end else if (rxbuf_rd || !rx_on) begin
                full_q <= 1'b0;
            end
        end
    end
    assign rx_buffer_full = full_q;

    ////////////////////////////////////////////////////////////////////////
    // Checks
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rst_n);

    logic after_rst_q, per_ok_q, rate_last_q;
    logic [4:0] base_cnt_q;
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            after_rst_q <= 1'b0;
            base_cnt_q <= 5'h00;
            per_ok_q <= 1'b0;
            rate_last_q <= 1'b1;
        end else begin
            after_rst_q <= 1'b1;
            if (clk_en && rx_restart) begin
                rate_last_q <= 1'b1;
            end else if (clk_en && half_tick) begin
                rate_last_q <= bit_rate_tick;
            end
            if (clk_en && (rx_restart || half_tick)) begin
                base_cnt_q <= 5'h00;
                per_ok_q <= 1'b1;
            end else if (clk_en && base_tick && serial_power_enable) begin
                base_cnt_q <= base_cnt_q + 5'h01;
            end
            if (clk_en && wr_baud) per_ok_q <= 1'b0;
        end
    end

    property p_reset_values;
        !after_rst_q |-> baud_q == uart_rx_pkg::BAUD_RESET &&
            port1_dir_q == uart_rx_pkg::PORT1_DIR_RESET;
    endproperty
    a_reset_values: assert property (p_reset_values)
        else $error("register reset value wrong");

    property p_disabled_clears;
        clk_en && !rx_on |=> status_q == uart_rx_pkg::STATUS_RESET;
    endproperty
    a_disabled_clears: assert property (p_disabled_clears)
        else $error("status not cleared while receive is off");

    property p_read_clears;
        clk_en && status_rd && !frame_done |=> status_q == 8'h00;
    endproperty
    a_read_clears: assert property (p_read_clears)
        else $error("status not cleared by read");

    property p_write_ignored;
        clk_en && cpu_wr_en && hit_status && rx_on && !frame_done &&
            !status_rd |=> $stable(status_q);
    endproperty
    a_write_ignored: assert property (p_write_ignored)
        else $error("status changed by write");

    property p_read_wait;
        clk_en && cpu_rd_en && hit_status && !wait_q |-> cpu_wait
            ##1 (cpu_rd_en && hit_status) [*1] |-> !cpu_wait;
    endproperty
    a_read_wait: assert property (p_read_wait)
        else $error("status read wait cycle wrong");

    property p_flags_at_end;
        clk_en && frame_done |=> status_q[uart_rx_pkg::FE_BIT] ==
            $past(~rx_bit) && status_q[uart_rx_pkg::OVE_BIT] ==
            $past(overrun);
    endproperty
    a_flags_at_end: assert property (p_flags_at_end)
        else $error("frame end flags wrong");

    property p_overrun_keeps;
        clk_en && frame_done && overrun |=> $stable(rxbuf_q) && full_q;
    endproperty
    a_overrun_keeps: assert property (p_overrun_keeps)
        else $error("overrun overwrote buffer");

    property p_no_pe_unchecked;
        clk_en && frame_done && !par_check |=>
            !status_q[uart_rx_pkg::PE_BIT];
    endproperty
    a_no_pe_unchecked: assert property (p_no_pe_unchecked)
        else $error("parity flag set with parity unchecked");

    property p_div_period;
        clk_en && half_tick && per_ok_q && divisor >= uart_rx_pkg::DIV_MIN
            |-> base_cnt_q + 5'h01 == divisor;
    endproperty
    a_div_period: assert property (p_div_period)
        else $error("divider period wrong");

    property p_rate_half;
        (bit_rate_tick |-> half_tick) and
            (clk_en && half_tick |-> bit_rate_tick != rate_last_q);
    endproperty
    a_rate_half: assert property (p_rate_half)
        else $error("bit rate tick without divider tick");

    c_frame: cover property (clk_en && frame_done);
    c_overrun: cover property (clk_en && frame_done && overrun);
    c_wait_read: cover property (cpu_wait ##1 status_rd);

endmodule
`default_nettype wire

// ---- verif/serial_station.sv ----
`timescale 1ns/1ns
`default_nettype none
module serial_station (
    input wire logic sys_clk,
    output logic line
);
    // Mark level between frames, as a real idle line rests
    initial line = 1'b1;

    task automatic put(input logic b, input int n);
        line = b;
        repeat (n) @(negedge sys_clk);
    endtask

    // Start, data LSB first, optional parity, one stop bit
    task automatic send(input logic [7:0] d, input int nb,
        input logic has_par, input logic par, input logic stop,
        input int bclk);
        put(1'b0, bclk);
        for (int i = 0; i < nb; i++) begin
            put(d[i], bclk);
        end
        if (has_par) begin
            put(par, bclk);
        end
        // Broken stop kept short so the false start after it fails its start bit check
        put(stop, stop ? bclk : bclk * 3 / 4);
        line = 1'b1;
    endtask
endmodule
`default_nettype wire

// ---- verif/test_uart_rx_error_and_baud_gen.sv ----
`timescale 1ns/1ns
`default_nettype none
module test_uart_rx_error_and_baud_gen;
    // fx/4 base, k = 8: one bit is 2 * 8 * 4 clocks
    localparam int BIT = 64;
    logic sys_clk = 1'b0;
    logic rst_n = 1'b0;
    logic clk_en = 1'b1;
    logic cpu_rd_en = 1'b0;
    logic cpu_wr_en = 1'b0;
    logic [15:0] cpu_addr = 16'h0000;
    logic [7:0] cpu_wdata = 8'h00;
    logic [7:0] cpu_rdata;
    logic cpu_wait;
    logic serial_power_enable = 1'b0;
    logic receive_enable = 1'b0;
    logic transmit_enable = 1'b0;
    logic [1:0] parity_select = 2'b00;
    logic char_len_8 = 1'b1;
    logic timer_fifty_output = 1'b0;
    logic timer_run = 1'b0;
    logic [1:0] tdiv = 2'b00;
    logic serial_rx_line;
    logic tx_pin_latch = 1'b1;
    logic tx_serial_data = 1'b1;
    logic serial_tx_line;
    logic serial_tx_oe_n;
    logic [7:0] port1_direction;
    logic bit_rate_tick;
    logic rx_buffer_full;
    int error_cnt = 0;
    int tests_run = 0;
    int cycles = 0;

    uart_rx_error_and_baud_gen DUT (
        .sys_clk(sys_clk), .rst_n(rst_n), .clk_en(clk_en),
        .cpu_addr(cpu_addr), .cpu_rd_en(cpu_rd_en), .cpu_wr_en(cpu_wr_en),
        .cpu_wdata(cpu_wdata), .cpu_rdata(cpu_rdata), .cpu_wait(cpu_wait),
        .serial_power_enable(serial_power_enable),
        .receive_enable(receive_enable), .transmit_enable(transmit_enable),
        .parity_select(parity_select), .char_len_8(char_len_8),
        .timer_fifty_output(timer_fifty_output),
        .serial_rx_line(serial_rx_line), .tx_pin_latch(tx_pin_latch),
        .tx_serial_data(tx_serial_data), .serial_tx_line(serial_tx_line),
        .serial_tx_oe_n(serial_tx_oe_n), .port1_direction(port1_direction),
        .bit_rate_tick(bit_rate_tick), .rx_buffer_full(rx_buffer_full)
    );
    serial_station st (.sys_clk(sys_clk), .line(serial_rx_line));

    always #2 sys_clk = ~sys_clk;

    // Timer source runs before it is selected, 50% duty, period 6
    always @(negedge sys_clk) begin
        if (timer_run) begin
            tdiv <= (tdiv == 2'd2) ? 2'd0 : tdiv + 2'd1;
            if (tdiv == 2'd2) timer_fifty_output <= ~timer_fifty_output;
        end
    end

    always @(posedge sys_clk) begin
        cycles <= cycles + 1;
        if (cycles == 40000) begin
            error_cnt = error_cnt + 1;
            tally_and_finish();
        end
    end

    ////////////////////////////////////////////////////////////////////
    task automatic tally_and_finish();
        $display("Checks %0d, mismatches %0d", tests_run, error_cnt);
        if (error_cnt == 0 && tests_run > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            error_cnt++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic wr(input logic [15:0] a, input logic [7:0] d);
        @(negedge sys_clk);
        cpu_addr = a;
        cpu_wdata = d;
        cpu_wr_en = 1'b1;
        @(negedge sys_clk);
        cpu_wr_en = 1'b0;
    endtask

    // Holds the request through any wait; w counts wait cycles
    task automatic rd(input logic [15:0] a, output logic [7:0] d,
        output int w);
        @(negedge sys_clk);
        cpu_addr = a;
        cpu_rd_en = 1'b1;
        #1 w = 0;
        while (cpu_wait !== 1'b0 && w < 4) begin
            @(negedge sys_clk);
            #1 w++;
        end
        @(negedge sys_clk);
        d = cpu_rdata;
        cpu_rd_en = 1'b0;
    endtask

    task automatic rchk(input logic [15:0] a, input logic [7:0] e);
        logic [7:0] d;
        int w;
        rd(a, d, w);
        chk(d, e);
    endtask

    task automatic frame(input logic [7:0] d, input logic bad,
        input logic stop);
        logic p;
        p = char_len_8 ? ^d : ^d[6:0];
        if (parity_select == uart_rx_pkg::PAR_ODD) p = ~p;
        if (parity_select == uart_rx_pkg::PAR_ZERO) p = 1'b0;
        st.send(d, char_len_8 ? 8 : 7,
            parity_select != uart_rx_pkg::PAR_NONE, p ^ bad, stop, BIT);
        repeat (2 * BIT) @(negedge sys_clk);
    endtask

    task automatic next_tick();
        int n;
        n = 0;
        do begin
            @(negedge sys_clk);
            n++;
        end while (bit_rate_tick !== 1'b1 && n < 3000);
    endtask

    ////////////////////////////////////////////////////////////////////
    task automatic t_reset();
        rchk(uart_rx_pkg::ADDR_BAUD, 8'h1f);
        rchk(uart_rx_pkg::ADDR_STATUS, 8'h00);
        rchk(uart_rx_pkg::ADDR_RXBUF, 8'hff);
        rchk(16'h0000, 8'h00);
        chk(port1_direction, 8'hff);
        chk(serial_tx_oe_n, 1'b1);
    endtask

    task automatic t_regs();
        logic [7:0] d;
        int w;
        wr(uart_rx_pkg::ADDR_BAUD, 8'hff);
        rchk(uart_rx_pkg::ADDR_BAUD, 8'hdf);
        wr(uart_rx_pkg::ADDR_STATUS, 8'h07);
        rd(uart_rx_pkg::ADDR_STATUS, d, w);
        chk(d, 8'h00);
        chk(w, 1);
        rd(uart_rx_pkg::ADDR_BAUD, d, w);
        chk(w, 0);
    endtask

    task automatic t_pins();
        wr(uart_rx_pkg::ADDR_PORT1_DIR, 8'hef);
        chk(serial_tx_oe_n, 1'b0);
        chk(port1_direction, 8'hef);
        serial_power_enable = 1'b1;
        transmit_enable = 1'b1;
        tx_serial_data = 1'b0;
        repeat (3) @(negedge sys_clk);
        chk(serial_tx_line, 1'b0);
        transmit_enable = 1'b0;
        repeat (3) @(negedge sys_clk);
        chk(serial_tx_line, 1'b1);
    endtask

    // Period of the bit rate tick for each base clock code
    task automatic t_baud();
        logic [7:0] brg [4] = '{8'h48, 8'h89, 8'hc8, 8'h08};
        int per [4] = '{64, 288, 1024, 96};
        int t0;
        timer_run = 1'b1;
        for (int i = 0; i < 4; i++) begin
            receive_enable = 1'b0;
            wr(uart_rx_pkg::ADDR_BAUD, brg[i]);
            receive_enable = 1'b1;
            next_tick();
            next_tick();
            t0 = cycles;
            next_tick();
            chk(cycles - t0, per[i]);
        end
        receive_enable = 1'b0;
        wr(uart_rx_pkg::ADDR_BAUD, 8'h48);
        receive_enable = 1'b1;
    endtask

    // Write while frozen must not land
    task automatic t_freeze();
        clk_en = 1'b0;
        wr(uart_rx_pkg::ADDR_BAUD, 8'h09);
        clk_en = 1'b1;
        rchk(uart_rx_pkg::ADDR_BAUD, 8'h48);
    endtask

    task automatic t_good();
        parity_select = uart_rx_pkg::PAR_EVEN;
        frame(8'h55, 1'b0, 1'b1);
        chk(rx_buffer_full, 1'b1);
        rchk(uart_rx_pkg::ADDR_STATUS, 8'h00);
        rchk(uart_rx_pkg::ADDR_RXBUF, 8'h55);
        char_len_8 = 1'b0;
        parity_select = uart_rx_pkg::PAR_ODD;
        frame(8'hb6, 1'b0, 1'b1);
        rchk(uart_rx_pkg::ADDR_STATUS, 8'h00);
        rchk(uart_rx_pkg::ADDR_RXBUF, 8'h36);
        char_len_8 = 1'b1;
    endtask

    task automatic t_parity();
        logic [1:0] m [3] = '{2'b10, 2'b11, 2'b01};
        for (int i = 0; i < 3; i++) begin
            parity_select = m[i];
            frame(8'h3c, 1'b1, 1'b1);
            rchk(uart_rx_pkg::ADDR_RXBUF, 8'h3c);
            rchk(uart_rx_pkg::ADDR_STATUS, i == 2 ? 8'h00 : 8'h04);
            rchk(uart_rx_pkg::ADDR_STATUS, 8'h00);
        end
        parity_select = uart_rx_pkg::PAR_NONE;
        frame(8'ha5, 1'b0, 1'b0);
        rchk(uart_rx_pkg::ADDR_STATUS, 8'h02);
        rchk(uart_rx_pkg::ADDR_RXBUF, 8'ha5);
    endtask

    // Back to back frames with one stop bit, buffer not read between them
    task automatic t_overrun();
        st.send(8'h11, 8, 1'b0, 1'b0, 1'b1, BIT);
        st.send(8'h22, 8, 1'b0, 1'b0, 1'b1, BIT);
        repeat (2 * BIT) @(negedge sys_clk);
        rchk(uart_rx_pkg::ADDR_STATUS, 8'h01);
        rchk(uart_rx_pkg::ADDR_RXBUF, 8'h11);
        frame(8'h33, 1'b0, 1'b1);
        frame(8'h44, 1'b0, 1'b0);
        rchk(uart_rx_pkg::ADDR_STATUS, 8'h03);
        rchk(uart_rx_pkg::ADDR_RXBUF, 8'h33);
    endtask

    task automatic t_clear();
        frame(8'h5a, 1'b0, 1'b0);
        receive_enable = 1'b0;
        repeat (3) @(negedge sys_clk);
        receive_enable = 1'b1;
        rchk(uart_rx_pkg::ADDR_STATUS, 8'h00);
        rchk(uart_rx_pkg::ADDR_RXBUF, 8'h5a);
        frame(8'h66, 1'b0, 1'b0);
        receive_enable = 1'b0;
        serial_power_enable = 1'b0;
        repeat (3) @(negedge sys_clk);
        serial_power_enable = 1'b1;
        rchk(uart_rx_pkg::ADDR_STATUS, 8'h00);
        rchk(uart_rx_pkg::ADDR_RXBUF, 8'hff);
    endtask

    initial begin
        repeat (8) @(negedge sys_clk);
        rst_n = 1'b1;
        t_reset();
        t_regs();
        t_pins();
        t_baud();
        t_freeze();
        t_good();
        t_parity();
        t_overrun();
        t_clear();
        tally_and_finish();
    end
endmodule
`default_nettype wire
